// ### nvmac_pkg.sv
/*
 * Package for the nonvolatile memory access controller: register byte
 * offsets, control bit positions, event numbering, widths and the
 * controller state encoding.
 * Assumes a 32-bit AHB-Lite register bus decoded on the low twelve address
 * bits, and an instruction clock that is also the bus clock.
 */
package nvmac_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int BUS_W  = 32;
	localparam int OFS_W  = 12;
	localparam int BYTE_W = 8;
	localparam int WORD_W = 16;
	localparam int IRQ_W  = 3;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [OFS_W-1:0] OFS_ADDR_LOW   = 12'h180;
	localparam logic [OFS_W-1:0] OFS_ADDR_HIGH  = 12'h184;
	localparam logic [OFS_W-1:0] OFS_FETCH_LOW  = 12'h188;
	localparam logic [OFS_W-1:0] OFS_CTRL       = 12'h18c;
	localparam logic [OFS_W-1:0] OFS_FETCH_HIGH = 12'h190;
	localparam logic [OFS_W-1:0] OFS_IRQ_STAT   = 12'h194;
	localparam logic [OFS_W-1:0] OFS_IRQ_MASK   = 12'h198;

	// ----------------------------------------------------------------
	// Control register bit positions
	// ----------------------------------------------------------------
	localparam int CTRL_SPACE  = 7;
	localparam int CTRL_ABORT  = 3;
	localparam int CTRL_PERMIT = 2;
	localparam int CTRL_STORE  = 1;
	localparam int CTRL_FETCH  = 0;

	// ----------------------------------------------------------------
	// Interrupt event bits
	// ----------------------------------------------------------------
	localparam int EV_FETCH = 0;
	localparam int EV_STORE = 1;
	localparam int EV_ABORT = 2;

	// ----------------------------------------------------------------
	// Bus constants and reset values
	// ----------------------------------------------------------------
	localparam int         HTRANS_ACTIVE = 1;
	localparam logic       RESP_OKAY     = 1'b0;
	localparam logic       READY_RESET   = 1'b1;
	localparam logic       SPACE_PROGRAM = 1'b1;

	// ----------------------------------------------------------------
	// Controller states, Gray coded along idle, fetch one, fetch two
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_FETCH1 = 2'b01,
		ST_FETCH2 = 2'b11,
		ST_STORE  = 2'b10
	} nvmac_state_e;

endpackage : nvmac_pkg

// ### nvmac_ahb_slave.sv
/*
 * AHB-Lite slave front end: captures the address phase, hands a write
 * strobe to the register file in the data phase and registers read data.
 * Assumes one slave on the bus, zero wait states, single word transfers.
 */
`timescale 1ns/1ps
`default_nettype none

module nvmac_ahb_slave
	import nvmac_pkg::*;
(
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             ce,
	input  wire logic             hsel,
	input  wire logic [BUS_W-1:0] haddr,
	input  wire logic [1:0]       htrans,
	input  wire logic             hwrite,
	input  wire logic             hready,
	input  wire logic [BUS_W-1:0] hwdata,
	output var  logic [BUS_W-1:0] hrdata,
	output var  logic             hreadyout,
	output var  logic             hresp,
	output var  logic [OFS_W-1:0] rd_ofs,
	input  wire logic [BUS_W-1:0] rd_data,
	output var  logic             wr_stb,
	output var  logic [OFS_W-1:0] wr_ofs,
	output var  logic [BUS_W-1:0] wr_data
);

	typedef struct packed {
		logic             wpend;
		logic [OFS_W-1:0] wofs;
		logic [BUS_W-1:0] rdata;
		logic             rdy;
		logic             resp;
	} nvmac_slv_s;

	nvmac_slv_s q;
	nvmac_slv_s d;
	logic       take;
	logic       hit;

	// Address phase decode; addresses above the map read zero, drop writes.
	always_comb begin
		take = hsel & htrans[HTRANS_ACTIVE] & hready;
		hit  = (haddr[BUS_W-1:OFS_W] == '0);
		d          = q;
		d.wpend    = take & hwrite & hit;
		d.wofs     = haddr[OFS_W-1:0];
		d.rdy      = READY_RESET;
		d.resp     = RESP_OKAY;
		if (take && !hwrite) begin
			d.rdata = hit ? rd_data : '0;
		end
	end

	// State register, frozen while the clock enable is low.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '{wpend: 1'b0, wofs: '0, rdata: '0, rdy: READY_RESET, resp: RESP_OKAY};
		end else if (ce) begin
			q <= d;
		end
	end

	assign rd_ofs    = haddr[OFS_W-1:0];
	assign wr_stb    = q.wpend;
	assign wr_ofs    = q.wofs;
	assign wr_data   = hwdata;
	assign hrdata    = q.rdata;
	assign hreadyout = q.rdy;
	assign hresp     = q.resp;

endmodule : nvmac_ahb_slave

`default_nettype wire

// ### nvmac_irq.sv
/*
 * Interrupt collector: sticky status bits set by events, cleared by writing
 * one, gated by a mask onto one level interrupt.
 * Assumes event pulses and write strobes synchronous to hclk.
 */
`timescale 1ns/1ps
`default_nettype none

module nvmac_irq
	import nvmac_pkg::*;
(
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             ce,
	input  wire logic [IRQ_W-1:0] events,
	input  wire logic             clr_stb,
	input  wire logic             mask_stb,
	input  wire logic [IRQ_W-1:0] wdata,
	output var  logic [IRQ_W-1:0] status,
	output var  logic [IRQ_W-1:0] mask,
	output var  logic             irq
);

	typedef struct packed {
		logic [IRQ_W-1:0] stat;
		logic [IRQ_W-1:0] mask;
		logic             irq;
	} nvmac_irq_s;

	nvmac_irq_s q;
	nvmac_irq_s d;

	// A new event wins over a clear in the same cycle.
	always_comb begin
		d = q;
		if (clr_stb) begin
			d.stat = q.stat & ~wdata;
		end
		d.stat = d.stat | events;
		if (mask_stb) begin
			d.mask = wdata;
		end
		d.irq = |(d.stat & d.mask);
	end

	// State register.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign status = q.stat;
	assign mask   = q.mask;
	assign irq    = q.irq;

endmodule : nvmac_irq

`default_nettype wire

// ### nvmac_core.sv
/*
 * Nonvolatile memory access controller: control register, address and
 * fetched-data registers, the two-cycle program fetch and the store launch
 * with abort tracking, reached over AHB-Lite.
 * Assumes the flash array answers a fetch within two cycles on
 * flash_rdata and signals the end of a store by flash_store_done.
 */
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// [R1] Software loads both address bytes, selects program space, then sets fetch.
// [R2] A fetch occupies the next two cycles; the core's next two instructions are dropped.
// [R3] The fetched word sits in the two fetched-data registers the following cycle.
// [R4] Fetched-data registers hold until another fetch or a software write.
// [R5] Abort flag sets when reset pin or watchdog cuts a store short.
// [R6] Store permit one allows stores; zero inhibits every store.
// [R7] Store launch is set-only by software, cleared by hardware at completion.
// [R8] Fetch launch is set-only by software, cleared by hardware at completion.
// [R9] Writing zero to either launch bit leaves a running operation alone.

module nvmac_core
	import nvmac_pkg::*;
(
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              ce,
	input  wire logic              hsel,
	input  wire logic [BUS_W-1:0]  haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic              hready,
	input  wire logic [BUS_W-1:0]  hwdata,
	output var  logic [BUS_W-1:0]  hrdata,
	output var  logic              hreadyout,
	output var  logic              hresp,
	output var  logic              irq,
	output var  logic              core_stall,
	output var  logic              flash_fetch,
	output var  logic              flash_store,
	output var  logic              flash_space,
	output var  logic [WORD_W-1:0] flash_addr,
	output var  logic [WORD_W-1:0] flash_wdata,
	input  wire logic [WORD_W-1:0] flash_rdata,
	input  wire logic              flash_store_done,
	input  wire logic              external_reset_pin_event,
	input  wire logic              watchdog_timer_reset
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------

	typedef struct packed {
		nvmac_state_e      st;
		logic              space;
		logic              abort;
		logic              permit;
		logic              store_go;
		logic              fetch_go;
		logic [BYTE_W-1:0] addr_lo;
		logic [BYTE_W-1:0] addr_hi;
		logic [BYTE_W-1:0] dat_lo;
		logic [BYTE_W-1:0] dat_hi;
		logic              rd;
		logic              wr;
		logic              stall;
	} nvmac_core_s;

	nvmac_core_s q;
	nvmac_core_s d;

	logic [OFS_W-1:0] rd_ofs;
	logic [BUS_W-1:0] rd_data;
	logic             wr_stb;
	logic [OFS_W-1:0] wr_ofs;
	logic [BUS_W-1:0] wr_data;
	logic [IRQ_W-1:0] events;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;
	logic [BYTE_W-1:0] ctrl_byte;
	logic             cut_short;
	logic             clr_stb;
	logic             mask_stb;

	// ----------------------------------------------------------------
	// Bus front end
	// ----------------------------------------------------------------

	// Transfers are always whole words, so hsize needs no decode.
	nvmac_ahb_slave u_slave (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.ce        (ce),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hready    (hready),
		.hwdata    (hwdata),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.rd_ofs    (rd_ofs),
		.rd_data   (rd_data),
		.wr_stb    (wr_stb),
		.wr_ofs    (wr_ofs),
		.wr_data   (wr_data)
	);

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------

	// Clear and mask strobes for the interrupt registers.
	assign clr_stb  = wr_stb & (wr_ofs == OFS_IRQ_STAT);
	assign mask_stb = wr_stb & (wr_ofs == OFS_IRQ_MASK);

	nvmac_irq u_irq (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.ce       (ce),
		.events   (events),
		.clr_stb  (clr_stb),
		.mask_stb (mask_stb),
		.wdata    (wr_data[IRQ_W-1:0]),
		.status   (irq_status),
		.mask     (irq_mask),
		.irq      (irq)
	);

	// ----------------------------------------------------------------
	// Read decode
	// ----------------------------------------------------------------

	// Control byte as software sees it; bits 6 to 4 read zero.
	always_comb begin
		ctrl_byte              = '0;
		ctrl_byte[CTRL_SPACE]  = q.space;
		ctrl_byte[CTRL_ABORT]  = q.abort;
		ctrl_byte[CTRL_PERMIT] = q.permit;
		ctrl_byte[CTRL_STORE]  = q.store_go;
		ctrl_byte[CTRL_FETCH]  = q.fetch_go;
	end

	// Read multiplexer; unmapped offsets return zero.
	always_comb begin
		rd_data = '0;
		if (rd_ofs == OFS_ADDR_LOW) begin
			rd_data[BYTE_W-1:0] = q.addr_lo;
		end else if (rd_ofs == OFS_ADDR_HIGH) begin
			rd_data[BYTE_W-1:0] = q.addr_hi;
		end else if (rd_ofs == OFS_FETCH_LOW) begin
			rd_data[BYTE_W-1:0] = q.dat_lo;
		end else if (rd_ofs == OFS_FETCH_HIGH) begin
			rd_data[BYTE_W-1:0] = q.dat_hi;
		end else if (rd_ofs == OFS_CTRL) begin
			rd_data[BYTE_W-1:0] = ctrl_byte;
		end else if (rd_ofs == OFS_IRQ_STAT) begin
			rd_data[IRQ_W-1:0] = irq_status;
		end else if (rd_ofs == OFS_IRQ_MASK) begin
			rd_data[IRQ_W-1:0] = irq_mask;
		end
	end

	// ----------------------------------------------------------------
	// Register writes and controller
	// ----------------------------------------------------------------

	// Either reset source cuts a running store short.
	assign cut_short = external_reset_pin_event | watchdog_timer_reset;

	// Software writes first, then the controller, so hardware wins ties.
	always_comb begin
		d      = q;
		events = '0;

		// Software register writes.
		if (wr_stb) begin
			if (wr_ofs == OFS_ADDR_LOW) begin
				d.addr_lo = wr_data[BYTE_W-1:0];
			end else if (wr_ofs == OFS_ADDR_HIGH) begin
				d.addr_hi = wr_data[BYTE_W-1:0];
			end else if (wr_ofs == OFS_FETCH_LOW) begin
				d.dat_lo = wr_data[BYTE_W-1:0]; // [R4]
			end else if (wr_ofs == OFS_FETCH_HIGH) begin
				d.dat_hi = wr_data[BYTE_W-1:0]; // [R4]
			end else if (wr_ofs == OFS_CTRL) begin
				// Memory space stays put while a store runs.
				if (q.st != ST_STORE) begin
					d.space = wr_data[CTRL_SPACE];
				end
				d.abort  = wr_data[CTRL_ABORT];
				d.permit = wr_data[CTRL_PERMIT];
				// Launch bits only ever set from software; zeros are dropped.
				if (q.st == ST_IDLE) begin
					if (wr_data[CTRL_FETCH]) begin
						d.fetch_go = 1'b1; // [R8] [R9]
					end else if (wr_data[CTRL_STORE] && d.permit) begin
						d.store_go = 1'b1; // [R6] [R7] [R9]
					end
				end
			end
		end

		// Controller sequence.
		case (q.st)
			ST_IDLE: begin
				if (d.fetch_go) begin
					// Launch the two-cycle fetch and hold off the core.
					d.st    = ST_FETCH1; // [R1] [R2]
					d.rd    = 1'b1;
					d.stall = 1'b1; // [R2]
				end else if (d.store_go) begin
					d.st = ST_STORE;
					d.wr = 1'b1; // [R6] [R7]
				end
			end
			ST_FETCH1: begin
				d.st = ST_FETCH2; // [R2]
			end
			ST_FETCH2: begin
				// Word lands in the fetched-data registers for next cycle.
				d.dat_lo   = flash_rdata[BYTE_W-1:0]; // [R3] [R4]
				d.dat_hi   = flash_rdata[WORD_W-1:BYTE_W]; // [R3] [R4]
				d.fetch_go = 1'b0; // [R8]
				d.rd       = 1'b0;
				d.stall    = 1'b0; // [R2]
				d.st       = ST_IDLE;
				events[EV_FETCH] = 1'b1;
			end
			ST_STORE: begin
				if (cut_short) begin
					// Reset event ends the store early; flag it.
					d.abort    = 1'b1; // [R5]
					d.store_go = 1'b0;
					d.wr       = 1'b0;
					d.st       = ST_IDLE;
					events[EV_ABORT] = 1'b1;
				end else if (flash_store_done) begin
					d.abort    = 1'b0; // [R5]
					d.store_go = 1'b0; // [R7]
					d.wr       = 1'b0;
					d.st       = ST_IDLE;
					events[EV_STORE] = 1'b1;
				end
			end
			default: begin
				d.st = ST_IDLE;
			end
		endcase
	end

	// State register, frozen while the clock enable is low.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all straight from state flip-flops
	// ----------------------------------------------------------------

	// Flash side and core stall.
	assign core_stall  = q.stall;
	assign flash_fetch = q.rd;
	assign flash_store = q.wr;
	assign flash_space = q.space;
	assign flash_addr  = {q.addr_hi, q.addr_lo};
	assign flash_wdata = {q.dat_hi, q.dat_lo};

endmodule : nvmac_core

`default_nettype wire

// ### nvmac_core_asserts.sv
/* Concurrent checks on the ports of the access controller.
   Assumes ce held high and the single hclk domain. */
`timescale 1ns/1ps
`default_nettype none
module nvmac_core_asserts
	import nvmac_pkg::*;
(
	input wire logic             hclk,
	input wire logic             hresetn,
	input wire logic [BUS_W-1:0] haddr,
	input wire logic             hwrite,
	input wire logic [BUS_W-1:0] hwdata,
	input wire logic             hreadyout,
	input wire logic             hresp,
	input wire logic             core_stall,
	input wire logic             flash_fetch,
	input wire logic             flash_store,
	input wire logic             flash_store_done,
	input wire logic             external_reset_pin_event,
	input wire logic             watchdog_timer_reset
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// A fetch holds the core for exactly two cycles.
	chk_stall_two: assert property ($rose(core_stall) |=> core_stall ##1 !core_stall)
		else $error("stall not two cycles");
	chk_fetch_stall: assert property (flash_fetch == core_stall)
		else $error("fetch and stall differ");
	// A fetch starts only from a control write with the fetch bit.
	chk_fetch_cause: assert property ($rose(flash_fetch) |-> $past(hwdata[CTRL_FETCH])
		&& $past(haddr[OFS_W-1:0], 2) == OFS_CTRL && $past(hwrite, 2))
		else $error("fetch without launch write");
	chk_store_cause: assert property ($rose(flash_store) |-> $past(hwdata[CTRL_STORE]))
		else $error("store without launch write");
	// Completion or a reset event ends a store at the next edge.
	chk_store_done: assert property (flash_store && flash_store_done |=> !flash_store)
		else $error("store not cleared on done");
	chk_store_abort: assert property (flash_store
		&& (external_reset_pin_event || watchdog_timer_reset) |=> !flash_store)
		else $error("store not cut by reset event");
	chk_no_overlap: assert property (!(flash_fetch && flash_store))
		else $error("fetch and store together");
	chk_ready_okay: assert property (hreadyout && hresp == RESP_OKAY)
		else $error("bus not ready or not okay");
endmodule : nvmac_core_asserts
bind nvmac_core nvmac_core_asserts u_chk (.hclk(hclk), .hresetn(hresetn), .haddr(haddr),
	.hwrite(hwrite), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
	.core_stall(core_stall), .flash_fetch(flash_fetch), .flash_store(flash_store),
	.flash_store_done(flash_store_done), .external_reset_pin_event(external_reset_pin_event),
	.watchdog_timer_reset(watchdog_timer_reset));
`default_nettype wire

// ### nvmac_flash_model.sv
/* Flash array model: answers fetches and ends stores after a set delay.
   Assumes the controller's registered fetch and store strobes. */
`timescale 1ns/1ps
`default_nettype none
module nvmac_flash_model
	import nvmac_pkg::*;
(
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              flash_fetch,
	input  wire logic              flash_store,
	input  wire logic [WORD_W-1:0] flash_addr,
	input  wire logic [3:0]        dly,
	output wire logic [WORD_W-1:0] flash_rdata,
	output wire logic              flash_store_done
);
	logic [3:0] cnt_q;
	// The word is a scramble of the address, inverted outside a fetch.
	assign flash_rdata = flash_fetch ? (flash_addr ^ 16'h5a3c) : ~(flash_addr ^ 16'h5a3c);
	// Store time counts from launch; done is raised only while the count equals dly.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) cnt_q <= 4'h0;
		else cnt_q <= flash_store ? cnt_q + 4'h1 : 4'h0;
	end
	assign flash_store_done = flash_store && (cnt_q == dly);
endmodule : nvmac_flash_model
`default_nettype wire

// ### nv_memory_access_control_tb.sv
/* Self-checking bench for the access controller over AHB-Lite.
   Assumes the flash model beside it and zero-wait bus answers. */
`timescale 1ns/1ps
`default_nettype none
module nv_memory_access_control_tb;
	import nvmac_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0] htrans = 2'h0, ev = 2'h0;
	logic [3:0] dly = 4'h6;
	logic [15:0] faddr, fwdata, frdata;
	logic hreadyout, hresp, irq, stall, ffetch, fstore, fspace, fdone;
	int failures = 0, checks_done = 0;
	wire hready = hreadyout;
	// Design, flash model beside it.
	nvmac_core dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hready), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
		.core_stall(stall), .flash_fetch(ffetch), .flash_store(fstore),
		.flash_space(fspace), .flash_addr(faddr), .flash_wdata(fwdata),
		.flash_rdata(frdata), .flash_store_done(fdone),
		.external_reset_pin_event(ev[0]), .watchdog_timer_reset(ev[1]));
	nvmac_flash_model u_flash (.hclk(hclk), .hresetn(hresetn), .flash_fetch(ffetch),
		.flash_store(fstore), .flash_addr(faddr), .dly(dly), .flash_rdata(frdata),
		.flash_store_done(fdone));
	// Clock of 10 ns.
	initial begin
		forever #5 hclk = ~hclk;
	end
	task finish_test;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : finish_test
	task chk(input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wait_rdy;
		int n;
		@(posedge hclk);
		for (n = 0; hready !== 1'b1; n++) begin
			if (n == 50) begin
				failures++;
				finish_test();
			end
			@(posedge hclk);
		end
	endtask : wait_rdy
	// One single word transfer: address phase, then data phase.
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		htrans <= 2'h2;
		haddr <= {20'h0, a};
		hwrite <= w;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		r = hrdata;
	endtask : bus
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask : wr
	task rd(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(exp, r);
	endtask : rd
	task t_reset;
		rd(12'h1a0, 32'h0);
		rd(OFS_IRQ_STAT, 32'h0);
		chk(32'h0, {30'h0, irq, fstore});
	endtask : t_reset
	// Program fetch of one word, then its two bytes are read back.
	task t_fetch(input logic [15:0] a);
		int n;
		logic [15:0] e;
		e = a ^ 16'h5a3c;
		wr(OFS_ADDR_LOW, {24'h0, a[7:0]});
		wr(OFS_ADDR_HIGH, {24'h0, a[15:8]});
		wr(OFS_CTRL, 32'h80);
		wr(OFS_CTRL, 32'h81);
		// Stall is looked at mid-cycle, away from the edges that move it.
		n = 0;
		repeat (4) begin
			@(negedge hclk);
			if (stall === 1'b1) n++;
		end
		@(posedge hclk);
		chk(32'd2, n);
		rd(OFS_FETCH_LOW, {24'h0, e[7:0]});
		rd(OFS_FETCH_HIGH, {24'h0, e[15:8]});
		rd(OFS_CTRL, 32'h80);
		chk(32'h1, {31'h0, fspace});
	endtask : t_fetch
	// Fetched bytes hold over unrelated writes, then follow a software write.
	task t_hold;
		wr(OFS_CTRL, 32'h80);
		wr(OFS_ADDR_LOW, 32'h0);
		rd(OFS_FETCH_LOW, 32'he0);
		rd(OFS_FETCH_HIGH, 32'ha4);
		wr(OFS_FETCH_LOW, 32'h5a);
		rd(OFS_FETCH_LOW, 32'h5a);
		chk(32'ha45a, {16'h0, fwdata});
	endtask : t_hold
	// Fetch status raised, masked, unmasked and cleared.
	task t_irq;
		rd(OFS_IRQ_STAT, 32'h1);
		chk(32'h0, {31'h0, irq});
		wr(OFS_IRQ_MASK, 32'h1);
		repeat (2) @(posedge hclk);
		chk(32'h1, {31'h0, irq});
		wr(OFS_IRQ_STAT, 32'h1);
		repeat (2) @(posedge hclk);
		chk(32'h0, {31'h0, irq});
	endtask : t_irq
	task t_store;
		int n;
		wr(OFS_CTRL, 32'h02);
		repeat (2) @(posedge hclk);
		chk(32'h0, {31'h0, fstore});
		wr(OFS_CTRL, 32'h06);
		// The launch edge moves the strobe, so look half a cycle later.
		@(negedge hclk);
		chk(32'h1, {31'h0, fstore});
		@(posedge hclk);
		wr(OFS_CTRL, 32'h04);
		chk(32'h1, {31'h0, fstore});
		for (n = 0; fstore !== 1'b0 && n < 40; n++) @(posedge hclk);
		chk(32'h0, {31'h0, fstore});
		if (fstore !== 1'b0) finish_test();
		rd(OFS_CTRL, 32'h04);
		rd(OFS_IRQ_STAT, 32'h2);
		wr(OFS_IRQ_STAT, 32'h2);
	endtask : t_store
	// Each reset event cuts a running store short.
	task t_abort;
		dly <= 4'hf;
		wr(OFS_IRQ_MASK, 32'h4);
		for (int i = 0; i < 2; i++) begin
			wr(OFS_CTRL, 32'h06);
			ev <= 2'h1 << i;
			@(posedge hclk);
			ev <= 2'h0;
			repeat (2) @(posedge hclk);
			chk(32'h0, {31'h0, fstore});
			rd(OFS_CTRL, 32'h0c);
			chk(32'h1, {31'h0, irq});
			wr(OFS_IRQ_STAT, 32'h4);
			wr(OFS_CTRL, 32'h04);
		end
		rd(OFS_IRQ_STAT, 32'h0);
	endtask : t_abort
	// Main sequence.
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_fetch(16'h1234);
		t_fetch(16'hfedc);
		t_hold();
		t_irq();
		t_store();
		t_abort();
		finish_test();
	end
endmodule : nv_memory_access_control_tb
`default_nettype wire
